// *** verilog/lcd_drive_defines.vh ***
// Constants for the segment LCD drive and update block.
// Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
`ifndef LCD_DRIVE_DEFINES_VH
`define LCD_DRIVE_DEFINES_VH
`define OFF_CTRL 8'h00
`define OFF_FCTRL 8'h04
`define OFF_STS 8'h08
`define OFF_STSCLR 8'h0C
`define OFF_RAM 8'h10
`define RAM_WORDS 4
`define RAM_IDX_W 2
// Control register fields
`define CTRL_EN 0
`define CTRL_SUPPLY_SOURCE_SELECT 1
`define CTRL_VOLTAGE_BUFFER_ENABLE 2
`define CTRL_MUX 3
`define CTRL_DUTY_LO 4
`define CTRL_DUTY_HI 6
// Frame control fields
`define FC_CON_LO 0
`define FC_CON_HI 2
`define FC_DEAD_LO 4
`define FC_DEAD_HI 6
`define FC_PULSE_LO 8
`define FC_PULSE_HI 10
`define FC_HIGH_DRIVE_ALWAYS_ON 12
`define FC_UPDATE_DONE_IRQ_ENABLE 13
// Status fields
`define STS_ENABLED_STATUS_FLAG 0
`define STS_RDY 1
`define STS_UDR 2
`define STS_UDD 3
// Duty codes and AXI response codes
`define DUTY_STATIC 3'h0
`define DUTY_1_2 3'h1
`define DUTY_1_3 3'h2
`define DUTY_1_4 3'h3
`define DUTY_1_8 3'h4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** verilog/lcd_drive.v ***
// Segment LCD drive sequencing, dead time, double buffer and pin map.
// Assumes phase_tick_i from an external frequency generator, one pulse per phase.
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
`include "lcd_drive_defines.vh"

// Summary of operation
// R1: Software picks external supply before enabling
// R2: Internal supply needs charge wait before enable
// R3: Contrast change applied only at frame start or while not running
// R4: Step-up converter off with external supply
// R5: Divider switch closes now, opens after even
// R6: Low-resistance switch off, pulsed, or always on
// R7: Buffer mode disables low-value network entirely
// R8: Buffer enable changed only while disabled
// R9: Ready set after settle, then drive starts
// R10: Dead time grounds all pins between frames
// R11: Request copies write buffer at frame boundary
// R12: Pending update blocks write buffer writes, keeps request
// R13: Copy done sets done flag, interrupt
// R14: Update finishes within two frame periods
// R15: No update while disabled, request stays pending
// R16: Low duties give 32 segments, 1-4 commons
// R17: Eighth duty uses top segments as commons
// R18: Remap moves segments 28-31 to pins 40-43
// R19: Disable grounds outputs and clears ready and enabled flags
// R20: Request flag clears when done flag sets
module lcd_drive #(
  parameter SETTLE_CYCLES = 16 // Phase ticks until drive levels are stable
) (
  input wire clk_i, // 200 MHz clock
  input wire rst_i, // Asynchronous reset, active high
  input wire phase_tick_i, // One-cycle pulse per LCD phase
  input wire [31:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output reg s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write strobes
  input wire s_axi_wvalid, // Write data valid
  output reg s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [31:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output reg s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  output reg [2:0] contrast_o, // Contrast applied to step-up
  output reg stepup_en_o, // Internal step-up converter on
  output reg divider_sw_o, // Divider enable switch closed
  output reg low_r_sw_o, // Low-resistance drive switch closed
  output reg high_net_en_o, // High-value network on
  output reg seg_active_o, // Pins driven (not grounded)
  output reg [2:0] phase_o, // Current phase index
  output reg frame_odd_o, // Odd frame of the pair
  output reg [7:0] com_sel_o, // Active common for this phase
  output reg [43:0] seg_pix_o, // Pixel state per segment pin
  output reg irq_o // Update-done interrupt
);

  reg [31:0] ctrl_r;
  reg [31:0] fctrl_r;
  reg rdy_r;
  reg udr_r;
  reg udd_r;
  reg [31:0] wbuf_r [0:`RAM_WORDS-1];
  reg [31:0] sbuf_r [0:`RAM_WORDS-1];
  reg [7:0] settle_r;
  reg [2:0] dead_r;
  reg [2:0] pulse_r;
  reg copy_r;
  reg [`RAM_IDX_W-1:0] cidx_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg [7:0] waddr_r;
  reg aw_have_r;
  reg w_have_r;
  integer i;

  wire en = ctrl_r[`CTRL_EN];
  wire supply_source_select = ctrl_r[`CTRL_SUPPLY_SOURCE_SELECT];
  wire voltage_buffer_enable = ctrl_r[`CTRL_VOLTAGE_BUFFER_ENABLE];
  wire remap = ctrl_r[`CTRL_MUX];
  wire [2:0] duty = ctrl_r[`CTRL_DUTY_HI:`CTRL_DUTY_LO];
  wire [2:0] dead_cfg = fctrl_r[`FC_DEAD_HI:`FC_DEAD_LO];
  wire [2:0] pulse_cfg = fctrl_r[`FC_PULSE_HI:`FC_PULSE_LO];
  wire high_drive_always_on = fctrl_r[`FC_HIGH_DRIVE_ALWAYS_ON];
  reg [2:0] last_phase;

  always @* begin
    case (duty)
      `DUTY_STATIC: last_phase = 3'h0;
      `DUTY_1_2: last_phase = 3'h1;
      `DUTY_1_3: last_phase = 3'h2;
      `DUTY_1_4: last_phase = 3'h3;
      default: last_phase = 3'h7;
    endcase
  end

  wire running = en & rdy_r;
  // Frame timing keeps going after disable until the even frame closes the pair
  wire counting = running | (~en & divider_sw_o);
  wire in_dead = dead_r != 3'h0;
  wire frame_end = running & phase_tick_i & ~in_dead & (phase_o == last_phase);
  // Frame start: the phase tick that ends a frame's dead time, or ends the frame itself when dead time is zero
  wire frame_start = frame_end & (dead_cfg == 3'h0) |
    running & phase_tick_i & (dead_r == 3'h1);

  // Write decode
  wire wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire wr_ram = waddr_r[7:4] == `OFF_RAM >> 4;
  wire [`RAM_IDX_W-1:0] wr_idx = waddr_r[`RAM_IDX_W+1:2];
  wire sts_clr = wr_go & (waddr_r == `OFF_STSCLR);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      waddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      ctrl_r <= 32'h00000000;
      fctrl_r <= 32'h00000000;
      for (i = 0; i < `RAM_WORDS; i = i + 1) begin
        wbuf_r[i] <= 32'h00000000;
      end
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        waddr_r <= s_axi_awaddr[7:0];
        aw_have_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_have_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        if (waddr_r == `OFF_CTRL) begin
          ctrl_r <= {25'h0000000, wdata_r[6:0]};
        end else if (waddr_r == `OFF_FCTRL) begin
          fctrl_r <= {18'h00000, wdata_r[13:0]};
        end else if (wr_ram & (waddr_r[1:0] == 2'h0)) begin
          if (udr_r) begin
            s_axi_bresp <= `RESP_SLVERR; // Write buffer locked [R12]
          end else begin
            for (i = 0; i < 4; i = i + 1) begin
              if (wstrb_r[i]) wbuf_r[wr_idx][i*8 +: 8] <= wdata_r[i*8 +: 8];
            end
          end
        end else if ((waddr_r != `OFF_STS) & (waddr_r != `OFF_STSCLR)) begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
        if (s_axi_araddr[7:0] == `OFF_CTRL) s_axi_rdata <= ctrl_r;
        else if (s_axi_araddr[7:0] == `OFF_FCTRL) s_axi_rdata <= fctrl_r;
        else if (s_axi_araddr[7:0] == `OFF_STS)
          s_axi_rdata <= {28'h0000000, udd_r, udr_r, rdy_r, seg_active_o | (en & rdy_r)};
        else if (s_axi_araddr[7:0] == `OFF_STSCLR) s_axi_rdata <= 32'h00000000;
        else if ((s_axi_araddr[7:4] == `OFF_RAM >> 4) & (s_axi_araddr[1:0] == 2'h0))
          s_axi_rdata <= wbuf_r[s_axi_araddr[`RAM_IDX_W+1:2]];
        else s_axi_rresp <= `RESP_SLVERR;
      end
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Drive sequencing, frame timing and double-buffer update
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdy_r <= 1'b0;
      settle_r <= 8'h00;
      udr_r <= 1'b0;
      udd_r <= 1'b0;
      copy_r <= 1'b0;
      cidx_r <= {`RAM_IDX_W{1'b0}};
      dead_r <= 3'h0;
      pulse_r <= 3'h0;
      phase_o <= 3'h0;
      frame_odd_o <= 1'b1;
      contrast_o <= 3'h0;
      stepup_en_o <= 1'b0;
      divider_sw_o <= 1'b0;
      low_r_sw_o <= 1'b0;
      high_net_en_o <= 1'b0;
      seg_active_o <= 1'b0;
      com_sel_o <= 8'h00;
      seg_pix_o <= 44'h00000000000;
      irq_o <= 1'b0;
      for (i = 0; i < `RAM_WORDS; i = i + 1) begin
        sbuf_r[i] <= 32'h00000000;
      end
    end else begin
      stepup_en_o <= en & ~supply_source_select; // [R4]
      high_net_en_o <= divider_sw_o;
      if (en) begin
        divider_sw_o <= 1'b1; // [R5]
      end else if (phase_tick_i & ~in_dead & ~frame_odd_o & (phase_o == last_phase)) begin
        divider_sw_o <= 1'b0; // Open only once the odd-even pair is done [R5]
      end
      if (frame_start | ~running) begin
        contrast_o <= fctrl_r[`FC_CON_HI:`FC_CON_LO]; // [R3]
      end
      // Ready after settling; drive waits on it [R9]
      if (~en) begin
        rdy_r <= 1'b0;
        settle_r <= 8'h00;
      end else if (~rdy_r & phase_tick_i) begin
        if (settle_r == SETTLE_CYCLES[7:0] - 8'h01) rdy_r <= 1'b1;
        else settle_r <= settle_r + 8'h01;
      end
      // Phase and dead time counters
      if (~counting) begin
        phase_o <= 3'h0;
        dead_r <= 3'h0;
        frame_odd_o <= 1'b1;
      end else if (phase_tick_i) begin
        if (in_dead) begin
          dead_r <= dead_r - 3'h1;
        end else if (phase_o == last_phase) begin
          phase_o <= 3'h0;
          frame_odd_o <= ~frame_odd_o;
          dead_r <= dead_cfg; // [R10]
        end else begin
          phase_o <= phase_o + 3'h1;
        end
      end
      // Pulse on each level change, always on, or off [R6]; buffer mode kills it [R7]
      if (~running | voltage_buffer_enable | (~high_drive_always_on & pulse_cfg == 3'h0)) begin
        pulse_r <= 3'h0;
        low_r_sw_o <= 1'b0;
      end else if (high_drive_always_on) begin
        low_r_sw_o <= 1'b1;
      end else if (phase_tick_i) begin
        pulse_r <= pulse_cfg;
        low_r_sw_o <= 1'b1;
      end else if (pulse_r != 3'h0) begin
        pulse_r <= pulse_r - 3'h1;
        low_r_sw_o <= pulse_r != 3'h1;
      end else begin
        low_r_sw_o <= 1'b0;
      end
      seg_active_o <= running & ~in_dead; // Same one-cycle lag as commons [R10] [R19]
      com_sel_o <= running ? (8'h01 << phase_o) : 8'h00; // [R16] [R17]
      if (~running | in_dead) begin
        seg_pix_o <= 44'h00000000000; // [R19]
      end else if (duty == `DUTY_1_8) begin
        seg_pix_o <= {12'h000, sbuf_r[phase_o[1:0]]}; // Top pins carry commons [R17]
      end else if (remap) begin
        seg_pix_o <= {sbuf_r[phase_o[1:0]][31:28], 8'h00, 4'h0,
          sbuf_r[phase_o[1:0]][27:0]}; // [R18]
      end else begin
        seg_pix_o <= {12'h000, sbuf_r[phase_o[1:0]]}; // [R16]
      end
      // Set wins over software clear of done
      if (sts_clr & wdata_r[`STS_UDD]) udd_r <= 1'b0;
      if (wr_go & (waddr_r == `OFF_STS) & wdata_r[`STS_UDR]) udr_r <= 1'b1; // [R11]
      if (running & udr_r & ~copy_r & frame_start) begin
        copy_r <= 1'b1; // Start at frame boundary; done well within two frames [R11] [R14]
        cidx_r <= {`RAM_IDX_W{1'b0}};
      end
      if (copy_r & en) begin // [R15]
        sbuf_r[cidx_r] <= wbuf_r[cidx_r];
        cidx_r <= cidx_r + 1'b1;
        if (cidx_r == `RAM_WORDS - 1) begin
          copy_r <= 1'b0;
          udr_r <= 1'b0; // [R20]
          udd_r <= 1'b1; // [R13]
        end
      end
      irq_o <= (udd_r | (copy_r & en & cidx_r == `RAM_WORDS - 1)) & fctrl_r[`FC_UPDATE_DONE_IRQ_ENABLE]; // [R13]
    end
  end
endmodule

// *** verif/lcd_drive_asserts.sv ***
// Checker for the LCD drive block, watching its top-level ports.
// Assumes a single clock domain with an asynchronous high reset.
`timescale 1ns/10ps
module lcd_drive_asserts (
  input wire clk_i, // Clock
  input wire rst_i, // Reset
  input wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, // Write address/data
  input wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, // Response, read addr
  input wire s_axi_rvalid, s_axi_rready, // Read data handshake
  input wire [31:0] s_axi_rdata, // Read data
  input wire seg_active_o, divider_sw_o, // Drive state
  input wire [2:0] contrast_o, phase_o, // Contrast and phase
  input wire [7:0] com_sel_o // Active common
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  AST_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("second write accepted");
  AST_DRIVE_START: assert property ($rose(seg_active_o) |-> divider_sw_o)
    else $error("pins driven before drive levels");
  AST_GROUND: assert property (!divider_sw_o |-> !seg_active_o)
    else $error("pins driven while switched off");
  AST_CONTRAST: assert property ($changed(contrast_o) |-> !seg_active_o || phase_o == 3'h0)
    else $error("contrast changed mid-frame");
  AST_ONE_COM: assert property (seg_active_o |-> $onehot0(com_sel_o))
    else $error("more than one common active");
endmodule
bind lcd_drive lcd_drive_asserts chk (.clk_i(clk_i), .rst_i(rst_i),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .seg_active_o(seg_active_o),
  .divider_sw_o(divider_sw_o), .contrast_o(contrast_o), .phase_o(phase_o),
  .com_sel_o(com_sel_o));

// *** verif/lcd_glass.sv ***
// Glass model: counts frames actually shown on the panel.
// Assumes commons one-hot and grounded pins while not driven.
`timescale 1ns/10ps
module lcd_glass (
  input wire clk_i, // Clock
  input wire seg_active_i, // Pins driven
  input wire [7:0] com_sel_i, // Active common
  output reg [7:0] frames_o // Shown frames
);
  reg com0_q;
  initial frames_o = 8'h00;
  initial com0_q = 1'b0;
  // A frame only counts when the first common is really driven
  always @(posedge clk_i) begin
    com0_q <= com_sel_i[0] & seg_active_i;
    if (com_sel_i[0] && seg_active_i && !com0_q) frames_o <= frames_o + 8'h01;
  end
endmodule

// *** verif/segment_lcd_drive_and_update_tb.sv ***
// Self-checking bench for the LCD drive block over AXI4-Lite.
// Assumes phase ticks every 8 clocks and a settle count of 2.
`timescale 1ns/10ps
`include "lcd_drive_defines.vh"
module segment_lcd_drive_and_update_tb;
  reg clk_i = 1'b0, rst_i = 1'b1, phase_tick_i = 1'b0;
  reg [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [2:0] contrast_o, phase_o;
  wire stepup_en_o, divider_sw_o, low_r_sw_o, high_net_en_o, seg_active_o, frame_odd_o, irq_o;
  wire [7:0] com_sel_o, frames;
  wire [43:0] seg_pix_o;
  integer n_errors = 0, compares = 0, cyc = 0;
  reg [2:0] tick_cnt = 3'h0;
  reg [31:0] d;
  reg [1:0] r;
  // Supply charge wait, scaled down: the model has no capacitor
  localparam integer CHARGE_WAIT = 400;
  lcd_drive #(.SETTLE_CYCLES(2)) dut (.clk_i(clk_i), .rst_i(rst_i), .phase_tick_i(phase_tick_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .contrast_o(contrast_o),
    .stepup_en_o(stepup_en_o), .divider_sw_o(divider_sw_o), .low_r_sw_o(low_r_sw_o),
    .high_net_en_o(high_net_en_o), .seg_active_o(seg_active_o), .phase_o(phase_o),
    .frame_odd_o(frame_odd_o), .com_sel_o(com_sel_o), .seg_pix_o(seg_pix_o), .irq_o(irq_o));
  lcd_glass glass (.clk_i(clk_i), .seg_active_i(seg_active_o), .com_sel_i(com_sel_o),
    .frames_o(frames));
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    tick_cnt <= tick_cnt + 3'h1;
    phase_tick_i <= (tick_cnt == 3'h7);
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  end
  task chk(input string name, input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task wr(input [31:0] a, input [31:0] v, output [1:0] resp);
    begin
      @(posedge clk_i);
      s_axi_awaddr <= a; s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      do begin
        @(posedge clk_i);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      do @(posedge clk_i); while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [31:0] a, output [31:0] v, output [1:0] resp);
    begin
      @(posedge clk_i);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      do @(posedge clk_i); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_i); while (!s_axi_rvalid);
      v = s_axi_rdata; resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  task poll(input integer b);
    do rd(`OFF_STS, d, r); while (d[b] !== 1'b1);
  endtask
  task t_idle;
    begin
      rd(`OFF_STS, d, r); chk("sts", d, 32'h0);
      rd(32'h40, d, r); chk("unmapped", {r, d[29:0]}, {`RESP_SLVERR, 30'h0});
      wr(`OFF_STS, 32'h4, r); repeat (100) @(posedge clk_i);
      rd(`OFF_STS, d, r); chk("pending", d[3:2], 2'h1);
      wr(`OFF_RAM, 32'hA5, r); chk("blocked", r, `RESP_SLVERR);
      $display("test idle done");
    end
  endtask
  task t_run;
    integer t0;
    begin
      wr(`OFF_FCTRL, 32'h3000, r);
      wr(`OFF_CTRL, 32'h32, r); // External supply picked first
      wr(`OFF_CTRL, 32'h33, r); // Only then enable
      poll(`STS_RDY); t0 = cyc;
      poll(`STS_UDD);
      chk("copy time", (cyc - t0) <= 80, 1);
      chk("flags", d[3:0], 4'hB);
      chk("irq", irq_o, 1'b1);
      chk("stepup", stepup_en_o, 1'b0);
      chk("low r", low_r_sw_o, 1'b1);
      wr(`OFF_RAM, 32'hA5, r); chk("ram ok", r, `RESP_OKAY);
      wr(`OFF_FCTRL, 32'h3005, r); repeat (100) @(posedge clk_i);
      chk("contrast", contrast_o, 3'h5);
      chk("shown", frames != 8'h00, 1);
      $display("test run done");
    end
  endtask
  task t_off;
    begin
      wr(`OFF_CTRL, 32'h32, r); repeat (200) @(posedge clk_i);
      chk("divider", divider_sw_o, 1'b0);
      chk("grounded", seg_active_o, 1'b0);
      rd(`OFF_STS, d, r); chk("enabled", d[0], 1'b0);
      wr(`OFF_CTRL, 32'h36, r); // Buffer mode chosen while disabled
      wr(`OFF_CTRL, 32'h37, r);
      @(posedge clk_i);
      chk("divider on", divider_sw_o, 1'b1);
      poll(`STS_RDY);
      chk("low r off", low_r_sw_o, 1'b0);
      chk("high net", high_net_en_o, 1'b1);
      $display("test off done");
    end
  endtask
  task t_drive;
    integer n;
    begin
      wr(`OFF_CTRL, 32'h36, r); repeat (100) @(posedge clk_i); // Disable first
      wr(`OFF_CTRL, 32'h38, r); // Internal supply, remap, no buffer
      wr(`OFF_FCTRL, 32'h2325, r); repeat (CHARGE_WAIT) @(posedge clk_i);
      wr(`OFF_CTRL, 32'h39, r);
      @(posedge clk_i);
      chk("stepup on", stepup_en_o, 1'b1);
      poll(`STS_RDY); repeat (8) @(posedge clk_i);
      n = 0;
      repeat (8) begin @(posedge clk_i); n = n + low_r_sw_o; end
      chk("pulse", n, 3);
      n = 0;
      repeat (48) begin @(posedge clk_i); n = n + !seg_active_o; end
      chk("dead", n, 16);
      wr(`OFF_STSCLR, 32'h8, r);
      wr(`OFF_RAM, 32'hF0000001, r);
      wr(`OFF_STS, 32'h4, r); poll(`STS_UDD);
      do @(posedge clk_i); while (!(com_sel_o[0] && seg_active_o));
      chk("remap hi", seg_pix_o[43:28], 16'hF000);
      chk("remap lo", seg_pix_o[27:0], 28'h0000001);
      wr(`OFF_CTRL, 32'h41, r); repeat (100) @(posedge clk_i);
      n = 0;
      repeat (80) begin @(posedge clk_i); n = n + com_sel_o[7]; end
      chk("com7", n, 8);
      do @(posedge clk_i); while (!(com_sel_o[0] && seg_active_o));
      chk("eighth", seg_pix_o[43:28], 16'h000F);
      $display("test drive done");
    end
  endtask
  task report_and_stop;
    begin
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_idle;
    t_run;
    t_off;
    t_drive;
    report_and_stop;
  end
endmodule
